//--- rtl/spi_status_flags.v
`timescale 1ns/1ps
`default_nettype none
`include "spi_status_regs.vh"

module spi_status_flags (
  input wire CLOCK_I,
  input wire RESETN_I,
  input wire [2:0] ADDR_I,
  input wire [15:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  output wire [15:0] RDATA_O,
  output wire IRQ_O,
  input wire SCLK_I,
  output wire SCLK_O,
  output wire SCLK_OE_O,
  input wire SDI_I,
  output wire SDO_O,
  input wire SSB_N_I,
  output wire SSB_N_O,
  output wire SSB_N_OE_O
);

  localparam [31:0] TICK_LAST = `SCLK_HALF_CYC - 1;

  // queue pointer step, shared by both queues
  function [1:0] nxt;
    input [1:0] p;
    begin
      nxt = p + 2'h1;
    end
  endfunction

  // ----------------------------------------
  // reset and pin synchronisers
  // ----------------------------------------
  reg rst_a_q;
  reg rst_q;
  wire rst_n;

  // release is synchronous so no flop sees a partial edge
  always @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rst_a_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_a_q <= 1'b1;
      rst_q <= rst_a_q;
    end
  end
  assign rst_n = rst_q;

  reg [2:0] pin1_q;
  reg [2:0] pin2_q;
  reg sclk_old_q;
  reg ssb_old_q;
  wire sclk_s;
  wire sdi_s;
  wire ssb_s;

  // {select, data, clock}; select idles high
  always @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      pin1_q <= 3'h4;
      pin2_q <= 3'h4;
      sclk_old_q <= 1'b0;
      ssb_old_q <= 1'b1;
    end else begin
      pin1_q <= {SSB_N_I, SDI_I, SCLK_I};
      pin2_q <= pin1_q;
      sclk_old_q <= pin2_q[0];
      ssb_old_q <= pin2_q[2];
    end
  end
  assign sclk_s = pin2_q[0];
  assign sdi_s = pin2_q[1];
  assign ssb_s = pin2_q[2];

  // ----------------------------------------
  // state declarations
  // ----------------------------------------
  reg txie_q;
  reg rxie_q;
  reg mstr_q;
  reg pe_q;
  reg mode_fault_detect_enable_q;
  reg txe_q;
  reg rxf_q;
  reg ovf_q;
  reg ovf_arm_q;
  reg mode_fault_flag_q;
  reg [3:0] ev_q;
  reg [3:0] mask_q;
  reg [15:0] rdata_q;

  reg [7:0] rx_mem [0:3];
  reg [1:0] rx_wp_q;
  reg [1:0] rx_rp_q;
  reg [2:0] rx_cnt_q;
  reg [7:0] tx_mem [0:3];
  reg [1:0] tx_wp_q;
  reg [1:0] tx_rp_q;
  reg [2:0] tx_cnt_q;

  reg busy_q;
  reg last_q;
  reg [2:0] bit_q;
  reg [7:0] sh_q;
  reg sdo_q;
  reg sclk_q;
  reg [7:0] div_q;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire wr_ctrl = WR_I && (ADDR_I == `A_CTRL);
  wire wr_data = WR_I && (ADDR_I == `A_DATA);
  wire wr_stat = WR_I && (ADDR_I == `A_IRQ_STAT);
  wire wr_mask = WR_I && (ADDR_I == `A_IRQ_MASK);
  wire rd_ctrl = RD_I && (ADDR_I == `A_CTRL);
  wire rd_data = RD_I && (ADDR_I == `A_DATA);

  // ----------------------------------------
  // shifter events
  // ----------------------------------------
  wire tx_have = (tx_cnt_q != 3'h0);
  wire tick = (div_q == TICK_LAST[7:0]);
  wire sclk_rise = sclk_s && !sclk_old_q;
  wire sclk_fall = !sclk_s && sclk_old_q;
  wire ssb_fall = !ssb_s && ssb_old_q;
  wire ssb_rise = ssb_s && !ssb_old_q;
  wire m_start = pe_q && mstr_q && !busy_q && tx_have;
  wire s_start = pe_q && !mstr_q && !busy_q && ssb_fall;
  wire rise = busy_q && (mstr_q ? (tick && !sclk_q) : sclk_rise);
  wire fall = busy_q && (mstr_q ? (tick && sclk_q) : sclk_fall);
  wire reload = fall && last_q && !mstr_q;
  wire load = s_start || reload;
  wire tx_pop = m_start || (load && tx_have);
  wire [7:0] tx_word = tx_mem[tx_rp_q];
  wire [7:0] rx_word = {sh_q[6:0], sdi_s};
  wire done = rise && (bit_q == `WORD_LAST);
  wire rx_full = (rx_cnt_q == `Q_FULL);
  wire rx_push = done && !rx_full;
  wire ovf_set = done && rx_full;
  wire rx_pop = rd_data && (rx_cnt_q != 3'h0);
  wire tx_push = wr_data && (tx_cnt_q != `Q_FULL);
  wire s_abort = busy_q && !mstr_q && ssb_rise;

  // mode fault in either role
  wire mode_fault_flag_slv = mode_fault_detect_enable_q && !mstr_q && s_abort && (bit_q != 3'h0);
  wire mode_fault_flag_mst = mode_fault_detect_enable_q && mstr_q && pe_q && !ssb_s;
  wire mode_fault_flag_set = mode_fault_flag_slv || mode_fault_flag_mst;

  // ----------------------------------------
  // control register and flags
  // ----------------------------------------
  // every hardware set takes priority over a clear in the same cycle
  always @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      txie_q <= 1'b0;
      rxie_q <= 1'b0;
      mstr_q <= 1'b0;
      pe_q <= 1'b0;
      mode_fault_detect_enable_q <= 1'b0;
      txe_q <= 1'b1;
      rxf_q <= 1'b0;
      ovf_q <= 1'b0;
      ovf_arm_q <= 1'b0;
      mode_fault_flag_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        txie_q <= WDATA_I[`B_TXIE];
        rxie_q <= WDATA_I[`B_RXIE];
        mstr_q <= WDATA_I[`B_MSTR];
        mode_fault_detect_enable_q <= WDATA_I[`B_MODE_FAULT_DETECT_ENABLE];
      end
      if (mode_fault_flag_mst) begin
        pe_q <= 1'b0;
      end else if (wr_ctrl) begin
        pe_q <= WDATA_I[`B_PE];
      end
      if (tx_pop && (tx_cnt_q == 3'h1) && !tx_push) begin
        txe_q <= 1'b1;
      end else if (wr_data) begin
        txe_q <= 1'b0;
      end
      if (rx_push && (rx_cnt_q == `Q_LAST)) begin
        rxf_q <= 1'b1;
      end else if (rd_data) begin
        rxf_q <= 1'b0;
      end
      if (ovf_set) begin
        ovf_q <= 1'b1;
      end else if (rd_data && ovf_arm_q) begin
        ovf_q <= 1'b0;
      end
      // arming needs a status read that actually showed the flag
      if (rd_ctrl && ovf_q) begin
        ovf_arm_q <= 1'b1;
      end else if (rd_data) begin
        ovf_arm_q <= 1'b0;
      end
      if (mode_fault_flag_set) begin
        mode_fault_flag_q <= 1'b1;
      end else if (wr_ctrl && WDATA_I[`B_MODE_FAULT_FLAG] && mode_fault_flag_q) begin
        mode_fault_flag_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // receive queue
  // ----------------------------------------
  // a full queue keeps its words, the new one is dropped
  always @(posedge CLOCK_I) begin
    if (rx_push) begin
      rx_mem[rx_wp_q] <= rx_word;
    end
  end

  always @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      rx_wp_q <= 2'h0;
      rx_rp_q <= 2'h0;
      rx_cnt_q <= 3'h0;
    end else begin
      if (rx_push) begin
        rx_wp_q <= nxt(rx_wp_q);
      end
      if (rx_pop) begin
        rx_rp_q <= nxt(rx_rp_q);
      end
      if (rx_push && !rx_pop) begin
        rx_cnt_q <= rx_cnt_q + 3'h1;
      end else if (rx_pop && !rx_push) begin
        rx_cnt_q <= rx_cnt_q - 3'h1;
      end
    end
  end

  // ----------------------------------------
  // transmit queue
  // ----------------------------------------
  // writes into a full queue are lost, as software was warned
  always @(posedge CLOCK_I) begin
    if (tx_push) begin
      tx_mem[tx_wp_q] <= WDATA_I[7:0];
    end
  end

  always @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      tx_wp_q <= 2'h0;
      tx_rp_q <= 2'h0;
      tx_cnt_q <= 3'h0;
    end else begin
      if (tx_push) begin
        tx_wp_q <= nxt(tx_wp_q);
      end
      if (tx_pop) begin
        tx_rp_q <= nxt(tx_rp_q);
      end
      if (tx_push && !tx_pop) begin
        tx_cnt_q <= tx_cnt_q + 3'h1;
      end else if (tx_pop && !tx_push) begin
        tx_cnt_q <= tx_cnt_q - 3'h1;
      end
    end
  end

  // ----------------------------------------
  // shifter, mode 0, msb first
  // ----------------------------------------
  // sample on rising clock, drive on falling; slave words run
  // back to back while select stays low
  always @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      last_q <= 1'b0;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      sdo_q <= 1'b0;
      sclk_q <= 1'b0;
      div_q <= 8'h00;
    end else if (!pe_q || s_abort) begin
      busy_q <= 1'b0;
      last_q <= 1'b0;
      bit_q <= 3'h0;
      sclk_q <= 1'b0;
      div_q <= 8'h00;
    end else if (m_start || s_start) begin
      busy_q <= 1'b1;
      bit_q <= 3'h0;
      sh_q <= tx_have ? tx_word : 8'h00;
      sdo_q <= tx_have ? tx_word[7] : 1'b0;
      div_q <= 8'h00;
    end else if (busy_q) begin
      // divider paces the master clock only
      div_q <= (tick || !mstr_q) ? 8'h00 : div_q + 8'h01;
      if (mstr_q && tick) begin
        sclk_q <= !sclk_q;
      end
      if (rise) begin
        sh_q <= rx_word;
        bit_q <= bit_q + 3'h1;
        last_q <= done;
      end else if (fall && last_q) begin
        last_q <= 1'b0;
        busy_q <= !mstr_q;
        if (reload) begin
          sh_q <= tx_have ? tx_word : 8'h00;
          sdo_q <= tx_have ? tx_word[7] : 1'b0;
        end
      end else if (fall) begin
        sdo_q <= sh_q[7];
      end
    end
  end

  // ----------------------------------------
  // interrupt events
  // ----------------------------------------
  // a request standing during the clear keeps its bit set
  wire [3:0] req;
  assign req[`EV_TXE] = txe_q && txie_q;
  assign req[`EV_RXF] = rxf_q && rxie_q;
  assign req[`EV_OVF] = ovf_q && rxie_q;
  assign req[`EV_MODE_FAULT_FLAG] = mode_fault_flag_q;

  always @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      ev_q <= 4'h0;
      mask_q <= `MASK_RST;
    end else begin
      ev_q <= (ev_q & ~(wr_stat ? WDATA_I[3:0] : 4'h0)) | req;
      if (wr_mask) begin
        mask_q <= WDATA_I[3:0];
      end
    end
  end

  assign IRQ_O = |(ev_q & mask_q);

  // ----------------------------------------
  // read data, valid the cycle after the strobe
  // ----------------------------------------
  always @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
    end else if (!RD_I) begin
      rdata_q <= 16'h0000;
    end else begin
      case (ADDR_I)
        `A_CTRL: begin
          rdata_q <= {5'h00, mode_fault_detect_enable_q, rxie_q, mstr_q, 2'h0, pe_q,
                      txie_q, rxf_q, ovf_q, mode_fault_flag_q, txe_q};
        end
        `A_DATA: begin
          rdata_q <= {8'h00, (rx_cnt_q != 3'h0) ? rx_mem[rx_rp_q] : 8'h00};
        end
        `A_COUNT: begin
          rdata_q <= {9'h000, `Q_FULL - tx_cnt_q, 1'b0, rx_cnt_q};
        end
        `A_IRQ_STAT: begin
          rdata_q <= {12'h000, ev_q};
        end
        `A_IRQ_MASK: begin
          rdata_q <= {12'h000, mask_q};
        end
        default: begin
          rdata_q <= 16'h0000;
        end
      endcase
    end
  end

  // ----------------------------------------
  // pins
  // ----------------------------------------
  // select is only driven when fault detection is off, since
  // detection needs the pin as an input
  assign RDATA_O = rdata_q;
  assign SCLK_O = sclk_q;
  assign SCLK_OE_O = pe_q && mstr_q;
  assign SDO_O = sdo_q;
  assign SSB_N_O = !busy_q;
  assign SSB_N_OE_O = pe_q && mstr_q && !mode_fault_detect_enable_q;

endmodule // spi_status_flags

`default_nettype wire

//--- rtl/spi_status_regs.vh
`ifndef SPI_STATUS_REGS_VH
`define SPI_STATUS_REGS_VH

// register indices on the plain port
`define A_CTRL 3'h0
`define A_DATA 3'h1
`define A_COUNT 3'h2
`define A_IRQ_STAT 3'h3
`define A_IRQ_MASK 3'h4

// status and control field positions
`define B_TXE 0
`define B_MODE_FAULT_FLAG 1
`define B_OVF 2
`define B_RXF 3
`define B_TXIE 4
`define B_PE 5
`define B_MSTR 8
`define B_RXIE 9
`define B_MODE_FAULT_DETECT_ENABLE 10

// event bits in the interrupt status and mask registers
`define EV_TXE 0
`define EV_RXF 1
`define EV_OVF 2
`define EV_MODE_FAULT_FLAG 3

// queue shape and reset values
`define Q_FULL 3'h4
`define Q_LAST 3'h3
`define WORD_LAST 3'h7
`define MASK_RST 4'h0

// serial clock half period when master
`define CLK_MHZ 200
`define SCLK_HALF_NS 50
`define SCLK_HALF_CYC (`SCLK_HALF_NS * `CLK_MHZ / 1000)

`endif

//--- tb/spi_far_master.sv
`timescale 1ns/1ps
`default_nettype none
// ------
// far-side master
// ------
module spi_far_master (
  output logic sclk_o,
  output logic ss_n_o,
  output logic sdi_o
);
  // clock stands still at 0 between frames
  initial begin
    sclk_o = 1'b0;
    ss_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  // msb first, data set while clock low; fewer than 8 bits cuts the word short
  task automatic send(input logic [7:0] w, input int n);
    // step off the system clock edge so no pin moves as it is sampled
    #1.25;
    ss_n_o = 1'b0;
    for (int i = 7; i > 7 - n; i--) begin
      sdi_o = w[i];
      #62.5 sclk_o = 1'b1;
      #62.5 sclk_o = 1'b0;
    end
    #62.5 ss_n_o = 1'b1;
    // data released: no pull, so show the opposite of the last bit
    sdi_o = ~sdi_o;
  endtask
  // hold select at a level, to fault a master
  task automatic hold(input logic v);
    #1.25;
    ss_n_o = v;
  endtask
endmodule // spi_far_master
`default_nettype wire

//--- tb/spi_flags_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "spi_status_regs.vh"
// ------
// port checks
// ------
module spi_flags_monitor (
  input wire logic CLOCK_I,
  input wire logic RESETN_I,
  input wire logic [2:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [15:0] RDATA_O,
  input wire logic IRQ_O,
  input wire logic SCLK_OE_O,
  input wire logic SSB_N_OE_O,
  input wire logic SSB_N_I
);
  logic [3:0] mask_q;
  logic [10:0] ctl_q;
  // mirrors of what software last wrote, so reads can be judged
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      mask_q <= 4'h0;
      ctl_q <= 11'h000;
    end else begin
      if (WR_I && ADDR_I == `A_IRQ_MASK) mask_q <= WDATA_I[3:0];
      if (WR_I && ADDR_I == `A_CTRL) ctl_q <= WDATA_I[10:0];
    end
  end
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RESETN_I);
  rdata_idle_a: assert property (!RD_I |=> RDATA_O == 16'h0000)
    else $error("read data not zero outside a read");
  unmapped_read_a: assert property (RD_I && ADDR_I > 3'h4 |=> RDATA_O == 16'h0000)
    else $error("unmapped read not zero");
  data_high_a: assert property (RD_I && ADDR_I == `A_DATA |=> RDATA_O[15:8] == 8'h00)
    else $error("data read high byte not zero");
  count_range_a: assert property (RD_I && ADDR_I == `A_COUNT |=>
    RDATA_O[2:0] <= 3'h4 && RDATA_O[6:4] <= 3'h4) else $error("word count beyond depth");
  ctrl_echo_a: assert property (RD_I && ADDR_I == `A_CTRL |=>
    RDATA_O[10:8] == ctl_q[10:8] && RDATA_O[4] == ctl_q[4]) else $error("enable bits lost");
  sclk_oe_a: assert property (SCLK_OE_O |-> ctl_q[`B_MSTR] && ctl_q[`B_PE])
    else $error("clock driven while not enabled master");
  mode_fault_flag_master_a: assert property ((SCLK_OE_O && !SSB_N_OE_O && !SSB_N_I) [*3]
    |-> ##[0:4] !SCLK_OE_O) else $error("master kept running with select low");
  irq_mask_a: assert property (mask_q == 4'h0 |-> !IRQ_O)
    else $error("interrupt with every event masked");
  cover property (IRQ_O);
  cover property ($fell(SCLK_OE_O));
  cover property (RD_I && ADDR_I == `A_DATA);
endmodule // spi_flags_monitor

bind spi_status_flags spi_flags_monitor u_mon (.CLOCK_I(CLOCK_I), .RESETN_I(RESETN_I),
  .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .IRQ_O(IRQ_O), .SCLK_OE_O(SCLK_OE_O), .SSB_N_OE_O(SSB_N_OE_O), .SSB_N_I(SSB_N_I));
`default_nettype wire

//--- tb/spi_status_flags_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "spi_status_regs.vh"
module spi_status_flags_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] v;
  logic [7:0] got = 8'h00;
  int err_total = 0;
  int comparisons = 0;
  wire [15:0] rdata;
  wire irq, sclk_out, sclk_oe, sdo, ss_out, ss_oe, far_sclk, far_ss_n, far_sdi;
  // pins: whoever enables drives, else the far side
  wire sclk_pin = sclk_oe ? sclk_out : far_sclk;
  wire ss_pin = ss_oe ? ss_out : far_ss_n;
  always #2.5 clk = ~clk;
  spi_status_flags u_dut (.CLOCK_I(clk), .RESETN_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .IRQ_O(irq), .SCLK_I(sclk_pin), .SCLK_O(sclk_out),
    .SCLK_OE_O(sclk_oe), .SDI_I(far_sdi), .SDO_O(sdo), .SSB_N_I(ss_pin), .SSB_N_O(ss_out),
    .SSB_N_OE_O(ss_oe));
  spi_far_master u_far (.sclk_o(far_sclk), .ss_n_o(far_ss_n), .sdi_o(far_sdi));
  // far slave: takes the master's data on its clock rise, only while selected
  always @(posedge sclk_out) begin
    if (!ss_out) got <= {got[6:0], sdo};
  end
  // ------
  // helpers, each entered and left at a rising edge
  // ------
  task automatic stop_test();
    if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string s, input logic [15:0] m, e, g);
    comparisons++;
    if ((g & m) !== e) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", s, e, g & m);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  // data stands only in the cycle after the strobe, so sample mid-cycle
  task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask
  task automatic look_irq(input string s, input logic e);
    @(posedge clk);
    @(negedge clk);
    chk(s, 16'h0001, {15'h0000, e}, {15'h0000, irq});
    @(posedge clk);
  endtask
  task automatic far(input logic [7:0] w, input int n);
    u_far.send(w, n);
    repeat (8) @(posedge clk);
  endtask
  // polling bound keeps a stuck flag from hanging the run
  task automatic wait_ctrl(input int b, input logic e);
    int n = 0;
    rd_reg(`A_CTRL, v);
    while (v[b] !== e && n < 300) begin
      rd_reg(`A_CTRL, v);
      n++;
    end
    if (v[b] !== e) begin
      err_total++;
      $display("unexpected ctrl bit %0d: expected %b, seen %b", b, e, v[b]);
      stop_test();
    end
  endtask
  // ------
  // scenarios
  // ------
  task automatic t_reset();
    rd_reg(`A_CTRL, v);
    chk("ctrl", 16'hFFFF, 16'h0001, v);
    rd_reg(`A_IRQ_MASK, v);
    chk("mask", 16'hFFFF, 16'h0000, v);
    rd_reg(3'h5, v);
    chk("unmapped", 16'hFFFF, 16'h0000, v);
  endtask
  task automatic t_tx();
    wr_reg(`A_IRQ_MASK, 16'h0001);
    wr_reg(`A_DATA, 16'h00A5);
    rd_reg(`A_CTRL, v);
    chk("txe after write", 16'h0001, 16'h0000, v);
    wr_reg(`A_CTRL, 16'h0120);
    wait_ctrl(`B_TXE, 1'b1);
    rd_reg(`A_COUNT, v);
    chk("free slots", 16'h0070, 16'h0040, v);
    rd_reg(`A_IRQ_STAT, v);
    chk("txe request gated", 16'h0001, 16'h0000, v);
    wr_reg(`A_CTRL, 16'h0130);
    look_irq("txe irq", 1'b1);
    wr_reg(`A_CTRL, 16'h0120);
    wr_reg(`A_IRQ_STAT, 16'h000F);
    look_irq("irq cleared", 1'b0);
    // let the master word finish before judging the link
    repeat (200) @(posedge clk);
    chk("sent word", 16'h00FF, 16'h00A5, {8'h00, got});
    chk("link idle", 16'h0003, 16'h0001, {14'h0000, sclk_out, ss_out});
    // the master also received a word of zeros; drain it so later queues start empty
    rd_reg(`A_DATA, v);
    chk("master rx word", 16'h00FF, 16'h0000, v);
  endtask
  task automatic t_mfm();
    wr_reg(`A_CTRL, 16'h0520);
    u_far.hold(1'b0);
    repeat (8) @(posedge clk);
    rd_reg(`A_CTRL, v);
    chk("master fault", 16'h0022, 16'h0002, v);
    u_far.hold(1'b1);
    wr_reg(`A_CTRL, 16'h0002);
    rd_reg(`A_CTRL, v);
    chk("fault cleared", 16'h0002, 16'h0000, v);
  endtask
  task automatic t_rx();
    wr_reg(`A_IRQ_MASK, 16'h0006);
    wr_reg(`A_CTRL, 16'h0020);
    for (int i = 1; i <= 4; i++) far(8'(i * 17), 8);
    rd_reg(`A_IRQ_STAT, v);
    chk("rx request gated", 16'h0002, 16'h0000, v);
    wr_reg(`A_CTRL, 16'h022E);
    look_irq("rx irq", 1'b1);
    rd_reg(`A_CTRL, v);
    chk("rx full", 16'h000C, 16'h0008, v);
    rd_reg(`A_COUNT, v);
    chk("rx count", 16'h0007, 16'h0004, v);
    far(8'h55, 8);
    rd_reg(`A_DATA, v);
    chk("oldest word", 16'h00FF, 16'h0011, v);
    rd_reg(`A_CTRL, v);
    chk("overflow kept", 16'h000C, 16'h0004, v);
    for (int i = 2; i <= 4; i++) begin
      rd_reg(`A_DATA, v);
      chk("queued word", 16'h00FF, 16'(i * 17), v);
    end
    rd_reg(`A_CTRL, v);
    chk("overflow cleared", 16'h0004, 16'h0000, v);
  endtask
  task automatic t_mfs();
    wr_reg(`A_CTRL, 16'h0420);
    far(8'hAA, 3);
    rd_reg(`A_CTRL, v);
    chk("slave fault", 16'h0002, 16'h0002, v);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_tx();
    t_mfm();
    t_rx();
    t_mfs();
    stop_test();
  end
endmodule // spi_status_flags_tb
`default_nettype wire
